// ### rtl/pcm_access.sv
// APB slave giving paged byte access to coefficient buffers and engine instruction memories
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module pcm_access (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Channel and engine state
  input  wire logic        adc_power_up,
  input  wire logic        dac_power_up,
  input  wire logic        adc_engine_prog_mode,
  input  wire logic        dac_engine_prog_mode,
  input  wire logic        frame_sync,
  // Engine side read ports
  input  wire logic [7:0]  adc_coef_addr,
  output logic      [23:0] adc_coef_data,
  input  wire logic [7:0]  dac_coef_addr,
  output logic      [23:0] dac_coef_data,
  input  wire logic [10:0] adc_instr_addr,
  output logic      [23:0] adc_instr_data,
  input  wire logic [10:0] dac_instr_addr,
  output logic      [23:0] dac_instr_data,
  // Status
  output logic             dac_active_buffer_flag
);
  // ------------------------------------------------------------
  // Storage, left unreset so the arrays map onto plain RAM
  // ------------------------------------------------------------
  logic [2:0][7:0] adca_mem [256];
  logic [2:0][7:0] daca_mem [256];
  logic [2:0][7:0] dacb_mem [256];
  logic [2:0][7:0] ains_mem [1050];
  logic [2:0][7:0] dins_mem [1050];

  logic [7:0]               page_q, page_d;
  pcm_pkg::pcm_ctrl_type    ctrl_q, ctrl_d;
  logic [31:0]              prdata_q, prdata_d;
  logic                     pready_q, pready_d;
  logic                     pslverr_q, pslverr_d;
  logic [23:0]              acoef_q, dcoef_q, ains_q, dins_q;

  pcm_pkg::pcm_region_type  region;
  logic [6:0]               reg_idx, wofs;
  logic [7:0]               rel;
  logic [10:0]              word, limit;
  logic [1:0]               lane, lsel;
  logic                     unmapped, in_win, allow, hit, wr_go, rd_go, swap_now;
  logic [2:0][7:0]          cur_word;

  // ------------------------------------------------------------
  // Access gating by channel power and engine mode
  // ------------------------------------------------------------
  // A powered DAC locks both buffers unless adaptive mode hands one over
  logic gate_adca, gate_daca, gate_dacb, gate_ains, gate_dins;

  always_comb begin
    gate_adca = !adc_power_up;
    gate_daca = !dac_power_up;
    gate_dacb = !dac_power_up;
    if (ctrl_q.dac_adaptive_enable) begin
      gate_daca = ctrl_q.dac_active_buffer_flag;
      gate_dacb = !ctrl_q.dac_active_buffer_flag;
    end
    gate_ains = !(adc_engine_prog_mode && adc_power_up);
    gate_dins = !(dac_engine_prog_mode && dac_power_up);
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  always_comb begin
    reg_idx  = paddr[pcm_pkg::IDX_LSB +: 7];
    unmapped = (paddr[31:9] != 23'h000000) || (paddr[1:0] != 2'h0);
    in_win   = reg_idx >= pcm_pkg::REG_WIN;
    wofs     = 7'(reg_idx - pcm_pkg::REG_WIN);
    lane     = wofs[1:0];
    lsel     = 2'(pcm_pkg::LANE_TOP - lane);
    region   = pcm_pkg::RG_NONE;
    rel      = 8'h00;
    limit    = pcm_pkg::COEF_N;
    allow    = 1'b0;
    if (page_q >= pcm_pkg::PG_ADCA_LO && page_q <= pcm_pkg::PG_ADCA_HI) begin
      region = pcm_pkg::RG_ADCA;
      rel    = 8'(page_q - pcm_pkg::PG_ADCA_LO);
      allow  = gate_adca;
    end else if (page_q >= pcm_pkg::PG_DACA_LO && page_q <= pcm_pkg::PG_DACA_HI) begin
      region = pcm_pkg::RG_DACA;
      rel    = 8'(page_q - pcm_pkg::PG_DACA_LO);
      allow  = gate_daca;
    end else if (page_q >= pcm_pkg::PG_DACB_LO && page_q <= pcm_pkg::PG_DACB_HI) begin
      region = pcm_pkg::RG_DACB;
      rel    = 8'(page_q - pcm_pkg::PG_DACB_LO);
      allow  = gate_dacb;
    end else if (page_q >= pcm_pkg::PG_AINS_LO && page_q <= pcm_pkg::PG_AINS_HI) begin
      region = pcm_pkg::RG_AINS;
      rel    = 8'(page_q - pcm_pkg::PG_AINS_LO);
      limit  = pcm_pkg::INSTR_N;
      allow  = gate_ains;
    end else if (page_q >= pcm_pkg::PG_DINS_LO && page_q <= pcm_pkg::PG_DINS_HI) begin
      region = pcm_pkg::RG_DINS;
      rel    = 8'(page_q - pcm_pkg::PG_DINS_LO);
      limit  = pcm_pkg::INSTR_N;
      allow  = gate_dins;
    end
    word = 11'(11'(rel) * pcm_pkg::SLOTS + 11'(wofs[6:2]));
    if (region == pcm_pkg::RG_DACA) begin
      word = 11'(word + pcm_pkg::DACA_FIRST);
    end
    // A blocked or out-of-range access falls through to zero, no stall
    hit = in_win && (region != pcm_pkg::RG_NONE) && (word < limit) && allow;
  end

  // ------------------------------------------------------------
  // Window read mux
  // ------------------------------------------------------------
  always_comb begin
    cur_word = 24'h000000;
    case (region)
      pcm_pkg::RG_ADCA: cur_word = adca_mem[word[7:0]];
      pcm_pkg::RG_DACA: cur_word = daca_mem[word[7:0]];
      pcm_pkg::RG_DACB: cur_word = dacb_mem[word[7:0]];
      pcm_pkg::RG_AINS: cur_word = ains_mem[word];
      pcm_pkg::RG_DINS: cur_word = dins_mem[word];
      default:          cur_word = 24'h000000;
    endcase
  end

  // ------------------------------------------------------------
  // APB handshake, one wait state
  // ------------------------------------------------------------
  always_comb begin
    rd_go     = psel && penable && !pready_q;
    wr_go     = psel && penable && pready_q && pwrite && !unmapped;
    pready_d  = rd_go;
    pslverr_d = rd_go && unmapped;
    prdata_d  = 32'h00000000;
    if (rd_go && !unmapped) begin
      if (reg_idx == pcm_pkg::REG_PAGE) begin
        prdata_d = 32'(page_q);
      end else if (reg_idx == pcm_pkg::REG_CTRL && page_q == pcm_pkg::PG_CTRL) begin
        prdata_d = 32'(ctrl_q);
      end else if (hit && lane != pcm_pkg::LANE_RSVD) begin
        prdata_d = 32'(cur_word[lsel]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ------------------------------------------------------------
  // Page select, one register shared by every page
  // ------------------------------------------------------------
  always_comb begin
    page_d = page_q;
    if (wr_go && reg_idx == pcm_pkg::REG_PAGE) begin
      page_d = pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      page_q <= pcm_pkg::PAGE_RST;
    end else begin
      page_q <= page_d;
    end
  end

  // ------------------------------------------------------------
  // Adaptive filter control
  // ------------------------------------------------------------
  // Registers 1 to 7 of other pages ignore writes and read zero
  always_comb begin
    ctrl_d   = ctrl_q;
    swap_now = ctrl_q.dac_adaptive_enable && ctrl_q.dac_buffer_swap_request && frame_sync;
    if (swap_now) begin
      ctrl_d.dac_active_buffer_flag  = !ctrl_q.dac_active_buffer_flag;
      ctrl_d.dac_buffer_swap_request = 1'b0;
    end
    // A host write in the swap cycle wins over the self-clear
    if (wr_go && reg_idx == pcm_pkg::REG_CTRL && page_q == pcm_pkg::PG_CTRL) begin
      ctrl_d.dac_adaptive_enable     = pwdata[pcm_pkg::CTRL_W-1];
      ctrl_d.dac_buffer_swap_request = pwdata[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= pcm_pkg::CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // Memory write strobes, one byte lane per access
  // ------------------------------------------------------------
  logic       wr_mem, we_adca, we_daca, we_dacb, we_ains, we_dins;
  logic [7:0] wr_byte;

  // A blocked or reserved-lane write raises no strobe, so storage keeps its value
  always_comb begin
    wr_mem  = wr_go && hit && lane != pcm_pkg::LANE_RSVD;
    we_adca = wr_mem && region == pcm_pkg::RG_ADCA;
    we_daca = wr_mem && region == pcm_pkg::RG_DACA;
    we_dacb = wr_mem && region == pcm_pkg::RG_DACB;
    we_ains = wr_mem && region == pcm_pkg::RG_AINS;
    we_dins = wr_mem && region == pcm_pkg::RG_DINS;
    wr_byte = pwdata[7:0];
  end

  // ------------------------------------------------------------
  // Memory writes, arrays left unreset
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (we_adca) begin
      adca_mem[word[7:0]][lsel] <= wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (we_daca) begin
      daca_mem[word[7:0]][lsel] <= wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (we_dacb) begin
      dacb_mem[word[7:0]][lsel] <= wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (we_ains) begin
      ains_mem[word][lsel] <= wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (we_dins) begin
      dins_mem[word][lsel] <= wr_byte;
    end
  end

  // ------------------------------------------------------------
  // Engine side reads; DAC filter uses buffer B only when flagged
  // ------------------------------------------------------------
  logic        use_b;
  logic [23:0] acoef_d, dcoef_d, ains_d, dins_d;

  always_comb begin
    use_b   = ctrl_q.dac_adaptive_enable && ctrl_q.dac_active_buffer_flag;
    acoef_d = adca_mem[adc_coef_addr];
    dcoef_d = use_b ? dacb_mem[dac_coef_addr] : daca_mem[dac_coef_addr];
    ains_d  = ains_mem[adc_instr_addr];
    dins_d  = dins_mem[dac_instr_addr];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acoef_q <= 24'h000000;
      dcoef_q <= 24'h000000;
      ains_q  <= 24'h000000;
      dins_q  <= 24'h000000;
    end else begin
      acoef_q <= acoef_d;
      dcoef_q <= dcoef_d;
      ains_q  <= ains_d;
      dins_q  <= dins_d;
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign adc_coef_data          = acoef_q;
  assign dac_coef_data          = dcoef_q;
  assign adc_instr_data         = ains_q;
  assign dac_instr_data         = dins_q;
  assign dac_active_buffer_flag = ctrl_q.dac_active_buffer_flag;
endmodule

// ### include/pcm_pkg.sv
// Constants and types for the paged coefficient and program memory access block
package pcm_pkg;
  // ------------------------------------------------------------
  // Register indices inside a page (byte address is index times 4)
  // ------------------------------------------------------------
  localparam int unsigned IDX_LSB = 2;
  localparam logic [6:0] REG_PAGE = 7'h00;
  localparam logic [6:0] REG_CTRL = 7'h01;
  localparam logic [6:0] REG_WIN  = 7'h08;
  localparam logic [7:0] PAGE_RST = 8'h00;
  // ------------------------------------------------------------
  // Page ranges
  // ------------------------------------------------------------
  localparam logic [7:0] PG_CTRL    = 8'h2C;
  localparam logic [7:0] PG_ADCA_LO = 8'h08;
  localparam logic [7:0] PG_ADCA_HI = 8'h10;
  localparam logic [7:0] PG_DACA_LO = 8'h2D;
  localparam logic [7:0] PG_DACA_HI = 8'h34;
  localparam logic [7:0] PG_DACB_LO = 8'h3E;
  localparam logic [7:0] PG_DACB_HI = 8'h46;
  localparam logic [7:0] PG_AINS_LO = 8'h50;
  localparam logic [7:0] PG_AINS_HI = 8'h72;
  localparam logic [7:0] PG_DINS_LO = 8'h98;
  localparam logic [7:0] PG_DINS_HI = 8'hBA;
  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam logic [10:0] SLOTS      = 11'h01E;
  localparam logic [10:0] DACA_FIRST = 11'h01E;
  localparam logic [10:0] COEF_N     = 11'h100;
  localparam logic [10:0] INSTR_N    = 11'h41A;
  localparam logic [1:0]  LANE_RSVD  = 2'h3;
  localparam logic [1:0]  LANE_TOP   = 2'h2;
  localparam int unsigned CTRL_W     = 3;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {RG_NONE, RG_ADCA, RG_DACA, RG_DACB, RG_AINS, RG_DINS} pcm_region_type;
  // Adaptive control: enable, active buffer flag, swap request
  typedef struct packed {
    logic dac_adaptive_enable;
    logic dac_active_buffer_flag;
    logic dac_buffer_swap_request;
  } pcm_ctrl_type;
  localparam pcm_ctrl_type CTRL_RST = pcm_ctrl_type'(3'h0);
endpackage

// ### bench/pcm_access_sva.sv
// Port checker for the paged memory access block
`timescale 1ns/1ps
module pcm_access_sva (
  // Clock, reset, APB and status
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_sync,
  input wire logic        dac_active_buffer_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  a_one_wait: assert property (s_setup |=> s_answer) else $error("late answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_map: assert property (pready |-> pslverr == (paddr[31:9] != 0 || paddr[1:0] != 0)) else $error("slverr");
  a_idle_zero: assert property (!pready |-> prdata == 0) else $error("data held");
  a_rsvd_zero: assert property (pready && !pwrite && paddr[8:2] inside {[2:7]} |-> prdata == 0) else $error("rsvd");
  a_lane_zero: assert property (pready && !pwrite && paddr[8:2] > 8 && paddr[3:2] == 3 |-> prdata == 0) else $error("lane");
  a_flag_frame: assert property ($changed(dac_active_buffer_flag) && !$past(sys_rst) |-> $past(frame_sync)) else $error("flag");
  a_rst_clear: assert property ($fell(sys_rst) |-> !dac_active_buffer_flag && !pready) else $error("not reset");
endmodule
bind pcm_access pcm_access_sva chk (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .frame_sync, .dac_active_buffer_flag);

// ### bench/pcm_host.sv
// Host controller model speaking APB to the block
`timescale 1ns/1ps
module pcm_host (
  // Clock and APB
  input wire logic        core_clk,
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic     [31:0] paddr,
  output logic     [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Released lines show the inverse, so a stale address or datum never passes by luck
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q, output logic e);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    {e, q} = {pslverr, prdata[7:0]};
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~{24'h0, d}};
  endtask
endmodule

// ### bench/pcm_access_tb.sv
// Self-checking bench for the paged memory access block
`timescale 1ns/1ps
`define CHK(n,x,s) begin n_tests++; if ((s)!==(x)) begin err_total++; $display("unexpected %s exp %h saw %h",n,x,s); end end
module pcm_access_tb;
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, frame_sync, flag, e;
  logic        adc_pu, dac_pu, adc_pm, dac_pm;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0]  ac_a, dc_a, q;
  logic [10:0] ai_a, di_a;
  logic [23:0] ac_d, dc_d, ai_d, di_d;
  int          err_total, n_tests;
  pcm_host h (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  pcm_access dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .adc_power_up(adc_pu), .dac_power_up(dac_pu), .adc_engine_prog_mode(adc_pm), .dac_engine_prog_mode(dac_pm),
    .frame_sync, .adc_coef_addr(ac_a), .adc_coef_data(ac_d), .dac_coef_addr(dc_a), .dac_coef_data(dc_d),
    .adc_instr_addr(ai_a), .adc_instr_data(ai_d), .dac_instr_addr(di_a), .dac_instr_data(di_d),
    .dac_active_buffer_flag(flag));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic op(input logic [3:0] pw, input logic w, input logic [7:0] p,
                    input logic [6:0] r, input logic [31:0] v);
    {adc_pu, dac_pu, adc_pm, dac_pm} <= pw;
    h.xfer(1'b1, 32'h0, p, q, e);
    for (int i = 0; i < 4; i++) begin
      h.xfer(w, {23'h0, r + 7'(i), 2'h0}, v[31-8*i -: 8], q, e);
      if (!w) `CHK("byte", v[31-8*i -: 8], q)
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    {adc_pu, dac_pu, adc_pm, dac_pm, frame_sync} = '0;
    {ac_a, dc_a, ai_a, di_a} = '0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    h.xfer(1'b0, 32'h0, 8'h00, q, e);
    `CHK("page", 8'h00, q)
    h.xfer(1'b0, 32'h201, 8'h00, q, e);
    `CHK("slverr", 1'b1, e)
    op(4'h0, 1'b0, 8'h2C, 7'h01, 32'h0);
    op(4'h0, 1'b1, 8'h09, 7'h7C, 32'h13579B00);
    op(4'h8, 1'b0, 8'h09, 7'h7C, 32'h0);
    op(4'h0, 1'b1, 8'h2D, 7'h08, 32'hA55A3C00);
    op(4'h4, 1'b1, 8'h2D, 7'h08, 32'h0);
    op(4'h4, 1'b0, 8'h2D, 7'h08, 32'h0);
    op(4'h0, 1'b0, 8'h2D, 7'h08, 32'hA55A3C00);
    op(4'h0, 1'b1, 8'h46, 7'h44, 32'h2468AC00);
    op(4'h0, 1'b1, 8'h2C, 7'h01, 32'h05000000);
    op(4'h0, 1'b0, 8'h2C, 7'h01, 32'h05000000);
    `CHK("flag", 1'b0, flag)
    op(4'h4, 1'b0, 8'h2D, 7'h08, 32'h0);
    op(4'h4, 1'b0, 8'h46, 7'h44, 32'h2468AC00);
    frame_sync <= 1'b1;
    @(posedge core_clk);
    frame_sync <= 1'b0;
    op(4'h4, 1'b0, 8'h2C, 7'h01, 32'h06000000);
    `CHK("flag", 1'b1, flag)
    op(4'h4, 1'b0, 8'h46, 7'h44, 32'h0);
    op(4'h4, 1'b0, 8'h2D, 7'h08, 32'hA55A3C00);
    op(4'h2, 1'b1, 8'h50, 7'h08, 32'hC0FFEE00);
    op(4'hA, 1'b0, 8'h50, 7'h08, 32'h0);
    op(4'h8, 1'b0, 8'h50, 7'h08, 32'hC0FFEE00);
    op(4'h4, 1'b1, 8'hBA, 7'h7C, 32'h0BEEF100);
    op(4'h5, 1'b0, 8'hBA, 7'h7C, 32'h0);
    {ac_a, dc_a, ai_a, di_a} <= {8'd59, 8'd255, 11'd0, 11'd1049};
    repeat (2) @(posedge core_clk);
    `CHK("adc coef", 24'h13579B, ac_d)
    `CHK("dac coef b", 24'h2468AC, dc_d)
    `CHK("adc instr", 24'hC0FFEE, ai_d)
    `CHK("dac instr", 24'h0BEEF1, di_d)
    conclude();
  end
endmodule
